// ---- shared/ebh_pkg.sv ----
/*
  Shared constants and types for the external bus pin stage: cycle status
  codes, bus states and timing counts.
  Assumes a single 10 MHz system clock from which the output clock is made.
*/
package ebh_pkg;

  // Active-low cycle status codes, bit 2 is the most significant pin.
  typedef enum logic [2:0] {
    EBH_CYC_INTACK = 3'h0,
    EBH_CYC_IO_RD = 3'h1,
    EBH_CYC_IO_WR = 3'h2,
    EBH_CYC_HALT = 3'h3,
    EBH_CYC_FETCH = 3'h4,
    EBH_CYC_MEM_RD = 3'h5,
    EBH_CYC_MEM_WR = 3'h6,
    EBH_CYC_PASSIVE = 3'h7
  } ebh_cycle_e;

  typedef enum logic [2:0] {
    EBH_ST_TI = 3'h0,
    EBH_ST_T1 = 3'h1,
    EBH_ST_T2 = 3'h2,
    EBH_ST_T3 = 3'h3,
    EBH_ST_T4 = 3'h4,
    EBH_ST_HOLD = 3'h5
  } ebh_state_e;

  localparam int EBH_SYS_CLK_NS = 100;
  // One bus state lasts one output-clock period.
  localparam int EBH_OUTCLK_NS = 200;
  localparam int EBH_PHASES = EBH_OUTCLK_NS / EBH_SYS_CLK_NS;
  // The plain address leads the muxed address by half an output period.
  localparam int EBH_ADDR_LEAD_CYC = EBH_PHASES / 2;

  localparam int EBH_ADDR_W = 20;
  localparam int EBH_DATA_W = 16;
  localparam int EBH_SYNC_STAGES = 2;

  localparam logic [EBH_ADDR_W-1:0] EBH_ADDR_RST = 20'h00000;
  localparam logic [EBH_DATA_W-1:0] EBH_DATA_RST = 16'h0000;
  localparam logic [EBH_DATA_W-1:0] EBH_CFG_RST = 16'h0000;
  localparam logic EBH_STRAP_RST = 1'b1;

endpackage

// ---- logic/ebh_sync.sv ----
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to i_sys_clk; only the second stage is
  visible to the caller.
*/
`timescale 1ns/1ps
module ebh_sync import ebh_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ebh_sync_s;

  ebh_sync_s sync_reg;
  ebh_sync_s sync_next;

  always_comb begin
    sync_next.meta = i_async;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.stable;

endmodule // ebh_sync

// ---- logic/ebh_bus_pins.sv ----
/*
  External local bus pin stage: runs T1..T4 bus cycles for a core request,
  drives status, address, data and strobes, captures reset straps and hands
  the bus to another master on hold.
  Assumes a 10 MHz clock, a synchronous active-high reset, and an outside
  wrapper that resolves the output enables into real pin levels.
*/
// Notes on behaviour
// - Status codes 001, 010, 101, 110 for I/O and memory reads and writes.
// - Fetch shows 100, halt 011, interrupt acknowledge 000, passive 111.
// - Top status bit marks memory, middle status bit marks write direction.
// - Status pins float during hold and reset unless boundary scan is enabled, which keeps the TDO pin driven.
// - With boundary scan enabled the status pins carry TDO, TCK and TMS.
// - Plain address appears half an output period before the muxed address.
// - Plain address pins float during hold and reset.
// - Muxed bus carries address in T1 and data in T2 through T4.
// - A low strap on the byte-enable pin at reset suppresses the address phase.
// - Muxed bus floats during hold and reset.
// - Muxed bus levels are captured into the config register when reset ends.
// - Upper write strobe is byte enable OR write strobe OR inverted address bit 0.
// - Lower write strobe is byte enable OR write strobe OR address bit 0.
// - Hold acknowledge rises at the end of T4 or an idle state.
// - During hold bus outputs float and chip selects are driven high.
// - Hold acknowledge drops and bus drive resumes once hold request goes low.
// - Byte enable with address bit 0 encodes width; asserted T1 through T3.
// - Write strobe is low in T2 and T3 of writes and floats in hold or reset.
`timescale 1ns/1ps
module ebh_bus_pins import ebh_pkg::*; #(
  parameter int AW = EBH_ADDR_W,
  parameter int DW = EBH_DATA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_kind,
  input wire logic [AW-1:0] i_req_addr,
  input wire logic [DW-1:0] i_req_wdata,
  input wire logic i_req_byte_high_enable_n,
  output logic o_req_ready,
  output logic [DW-1:0] o_rdata,
  output logic o_rdata_valid,
  input wire logic i_jtag_enable,
  input wire logic i_jtag_tdo,
  output logic o_jtag_tck,
  output logic o_jtag_tms,
  output logic o_output_clock_primary,
  output logic [2:0] o_cycle_status_n,
  output logic [2:0] o_cycle_status_oe,
  input wire logic [2:0] i_cycle_status_pin,
  output logic [AW-1:0] o_plain_address_bus,
  output logic o_plain_address_oe,
  input wire logic [DW-1:0] i_muxed_addr_data_bus,
  output logic [DW-1:0] o_muxed_addr_data_bus,
  output logic o_muxed_addr_data_oe,
  input wire logic i_byte_high_enable_pin,
  output logic o_byte_high_enable_n,
  output logic o_byte_high_enable_oe,
  output logic o_write_strobe_n,
  output logic o_write_upper_byte_n,
  output logic o_write_lower_byte_n,
  output logic o_transceiver_enable_n,
  output logic o_transfer_direction,
  output logic o_strobes_oe,
  input wire logic i_hold_request,
  output logic o_hold_acknowledge,
  output logic [DW-1:0] o_reset_config_register,
  output logic o_address_phase_enabled,
  input wire logic i_upper_memory_select_n,
  input wire logic i_lower_memory_select_n,
  input wire logic [3:0] i_midrange_memory_selects_n,
  input wire logic [6:0] i_peripheral_selects_n,
  output logic o_upper_memory_select_n,
  output logic o_lower_memory_select_n,
  output logic [3:0] o_midrange_memory_selects_n,
  output logic [6:0] o_peripheral_selects_n
);

  typedef struct packed {
    ebh_state_e st;
    logic ph;
    ebh_cycle_e kind;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic bhe_n;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic [DW-1:0] cfg;
    logic adr_en;
    logic rst_q;
  } ebh_bus_s;

  ebh_bus_s bus_reg;
  ebh_bus_s bus_next;

  logic [DW+4-1:0] pins_sync;
  logic hold_sync;
  logic strap_sync;
  logic [DW-1:0] ad_sync;
  logic float_bus;
  logic is_write;
  logic in_access;

  function automatic logic kind_is_write(input ebh_cycle_e k);
    return (k == EBH_CYC_IO_WR) || (k == EBH_CYC_MEM_WR);
  endfunction

  function automatic logic kind_moves_data(input ebh_cycle_e k);
    return (k != EBH_CYC_HALT) && (k != EBH_CYC_PASSIVE);
  endfunction

  // Hold, strap, muxed bus and scan pins all come from outside this clock.
  ebh_sync #(
    .WIDTH(DW + 4)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(1'b0),
    .i_async({i_hold_request, i_byte_high_enable_pin, i_cycle_status_pin[1:0],
      i_muxed_addr_data_bus}),
    .o_sync(pins_sync)
  );

  assign hold_sync = pins_sync[DW+3];
  assign strap_sync = pins_sync[DW+2];
  assign ad_sync = pins_sync[DW-1:0];
  assign o_jtag_tck = pins_sync[DW+1];
  assign o_jtag_tms = pins_sync[DW];

  always_comb begin
    bus_next = bus_reg;
    bus_next.ph = ~bus_reg.ph;
    bus_next.rvalid = 1'b0;
    bus_next.rst_q = 1'b0;
    // The reset config is taken on the first cycle out of reset.
    if (bus_reg.rst_q) begin
      bus_next.cfg = ad_sync;
      bus_next.adr_en = strap_sync;
    end
    if (bus_reg.ph) begin
      case (bus_reg.st)
        EBH_ST_TI: begin
          if (hold_sync) begin
            bus_next.st = EBH_ST_HOLD;
          end else if (i_req_valid) begin
            bus_next.st = EBH_ST_T1;
            bus_next.kind = ebh_cycle_e'(i_req_kind);
            bus_next.addr = i_req_addr;
            bus_next.wdata = i_req_wdata;
            bus_next.bhe_n = i_req_byte_high_enable_n;
          end
        end
        EBH_ST_T1: bus_next.st = EBH_ST_T2;
        EBH_ST_T2: bus_next.st = EBH_ST_T3;
        EBH_ST_T3: bus_next.st = EBH_ST_T4;
        EBH_ST_T4: begin
          bus_next.st = hold_sync ? EBH_ST_HOLD : EBH_ST_TI;
          if (!kind_is_write(bus_reg.kind) && kind_moves_data(bus_reg.kind)) begin
            bus_next.rdata = ad_sync;
            bus_next.rvalid = 1'b1;
          end
        end
        EBH_ST_HOLD: begin
          if (!hold_sync) begin
            bus_next.st = EBH_ST_TI;
          end
        end
        default: bus_next.st = EBH_ST_TI;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_reg.st <= EBH_ST_TI;
      bus_reg.ph <= 1'b0;
      bus_reg.kind <= EBH_CYC_PASSIVE;
      bus_reg.addr <= EBH_ADDR_RST;
      bus_reg.wdata <= EBH_DATA_RST;
      bus_reg.bhe_n <= 1'b1;
      bus_reg.rdata <= EBH_DATA_RST;
      bus_reg.rvalid <= 1'b0;
      bus_reg.cfg <= EBH_CFG_RST;
      bus_reg.adr_en <= EBH_STRAP_RST;
      bus_reg.rst_q <= 1'b1;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Floating is gated straight from reset so the pins let go at once.
  assign float_bus = i_reset || (bus_reg.st == EBH_ST_HOLD);
  assign is_write = kind_is_write(bus_reg.kind);
  assign in_access = (bus_reg.st == EBH_ST_T2) || (bus_reg.st == EBH_ST_T3);

  assign o_req_ready = !i_reset && (bus_reg.st == EBH_ST_TI) && bus_reg.ph && !hold_sync;
  assign o_rdata = bus_reg.rdata;
  assign o_rdata_valid = bus_reg.rvalid;
  assign o_output_clock_primary = ~bus_reg.ph;
  assign o_hold_acknowledge = (bus_reg.st == EBH_ST_HOLD);
  assign o_reset_config_register = bus_reg.cfg;
  assign o_address_phase_enabled = bus_reg.adr_en;

  // Status shows the cycle code through T1 and T2, then goes passive.
  always_comb begin
    if ((bus_reg.st == EBH_ST_T1) || (bus_reg.st == EBH_ST_T2)) begin
      o_cycle_status_n = bus_reg.kind;
    end else begin
      o_cycle_status_n = EBH_CYC_PASSIVE;
    end
    if (i_jtag_enable) begin
      o_cycle_status_n[2] = i_jtag_tdo;
      o_cycle_status_oe = 3'h4;
    end else begin
      o_cycle_status_oe = float_bus ? 3'h0 : 3'h7;
    end
  end

  // The plain address changes at T1 start, the muxed address one phase later.
  assign o_plain_address_bus = bus_reg.addr;
  assign o_plain_address_oe = !float_bus;

  always_comb begin
    o_muxed_addr_data_bus = bus_reg.wdata;
    o_muxed_addr_data_oe = 1'b0;
    if (!float_bus) begin
      if ((bus_reg.st == EBH_ST_T1) && bus_reg.ph && bus_reg.adr_en) begin
        o_muxed_addr_data_bus = bus_reg.addr[DW-1:0];
        o_muxed_addr_data_oe = 1'b1;
      end else if (is_write && (in_access || (bus_reg.st == EBH_ST_T4))) begin
        o_muxed_addr_data_oe = 1'b1;
      end
    end
  end

  assign o_byte_high_enable_n = !((bus_reg.st == EBH_ST_T1) || in_access) || bus_reg.bhe_n;
  assign o_byte_high_enable_oe = !float_bus;
  assign o_write_strobe_n = !(in_access && is_write);
  assign o_write_upper_byte_n = o_byte_high_enable_n || o_write_strobe_n || !bus_reg.addr[0];
  assign o_write_lower_byte_n = o_byte_high_enable_n || o_write_strobe_n || bus_reg.addr[0];
  assign o_transceiver_enable_n = !(in_access && kind_moves_data(bus_reg.kind));
  assign o_transfer_direction = is_write;
  assign o_strobes_oe = !float_bus;

  // Chip selects are never floated; hold forces them inactive instead.
  assign o_upper_memory_select_n = float_bus || i_upper_memory_select_n;
  assign o_lower_memory_select_n = float_bus || i_lower_memory_select_n;
  assign o_midrange_memory_selects_n = float_bus ? 4'hf : i_midrange_memory_selects_n;
  assign o_peripheral_selects_n = float_bus ? 7'h7f : i_peripheral_selects_n;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_status_passive_late: assert property (
    (bus_reg.st inside {EBH_ST_T3, EBH_ST_T4, EBH_ST_TI}) && !i_jtag_enable
      |-> o_cycle_status_n == EBH_CYC_PASSIVE)
    else $error("status not passive outside T1-T2");
  a_status_code_kind: assert property (
    $rose(bus_reg.st == EBH_ST_T1) && !i_jtag_enable
      |-> o_cycle_status_n == bus_reg.kind ##2 o_cycle_status_n == $past(bus_reg.kind, 2))
    else $error("status code does not follow the cycle kind");
  a_hold_floats_all: assert property (
    o_hold_acknowledge |-> !o_plain_address_oe && !o_muxed_addr_data_oe && !o_strobes_oe
      && o_upper_memory_select_n && (o_peripheral_selects_n == 7'h7f))
    else $error("bus driven during hold");
  a_reset_floats: assert property (disable iff (1'b0)
    i_reset |-> !o_plain_address_oe && !o_muxed_addr_data_oe && !o_strobes_oe)
    else $error("bus driven during reset");
  a_hold_ack_timing: assert property (
    $rose(o_hold_acknowledge) |-> $past(bus_reg.st) inside {EBH_ST_T4, EBH_ST_TI}
      && $past(hold_sync) && $past(bus_reg.ph))
    else $error("hold acknowledge outside T4 or Ti end");
  a_hold_release: assert property (
    o_hold_acknowledge && !hold_sync |-> ##[1:2] !o_hold_acknowledge)
    else $error("hold acknowledge stuck after request drop");
  a_write_strobe_win: assert property (
    !o_write_strobe_n |-> bus_reg.st inside {EBH_ST_T2, EBH_ST_T3} && kind_is_write(bus_reg.kind))
    else $error("write strobe outside T2-T3 of a write");
  a_write_strobe_len: assert property (
    $fell(o_write_strobe_n) |-> (!o_write_strobe_n) [*4] ##1 o_write_strobe_n)
    else $error("write strobe not low for exactly T2 and T3");
  a_addr_lead_half: assert property (
    $rose(bus_reg.st == EBH_ST_T1) && bus_reg.adr_en |-> !o_muxed_addr_data_oe
      ##1 o_muxed_addr_data_oe && o_muxed_addr_data_bus == o_plain_address_bus[DW-1:0])
    else $error("muxed address not one phase after plain address");
  a_strap_suppress: assert property (
    !bus_reg.adr_en && (bus_reg.st == EBH_ST_T1) |-> !o_muxed_addr_data_oe)
    else $error("address phase driven while strapped off");
  a_byte_strobes: assert property (
    !o_write_upper_byte_n |-> !o_byte_high_enable_n && bus_reg.addr[0] && !o_write_strobe_n)
    else $error("upper byte strobe without its terms");
  a_lower_byte_strobe: assert property (
    !o_write_lower_byte_n |-> !o_byte_high_enable_n && !bus_reg.addr[0] && !o_write_strobe_n)
    else $error("lower byte strobe without its terms");
  a_read_data_time: assert property (
    $rose(bus_reg.st == EBH_ST_T1) && kind_moves_data(bus_reg.kind)
      && !kind_is_write(bus_reg.kind) |-> ##8 o_rdata_valid)
    else $error("read data not delivered at the end of T4");
  a_config_capture: assert property (
    $fell(i_reset) |=> o_reset_config_register == $past(ad_sync)
      && o_address_phase_enabled == $past(strap_sync))
    else $error("reset configuration not captured at reset release");

  c_mem_write: cover property ($rose(o_write_strobe_n == 1'b0) && bus_reg.kind == EBH_CYC_MEM_WR);
  c_read_done: cover property (o_rdata_valid);
  c_hold_cycle: cover property ($rose(o_hold_acknowledge) ##[1:40] $fell(o_hold_acknowledge));
  c_scan_mode: cover property (i_jtag_enable && o_cycle_status_oe == 3'h4);

endmodule // ebh_bus_pins

// ---- verif/ebh_far_side.sv ----
/*
  Far-side model of the bus pin stage: the pull network on the muxed bus and
  on the byte-enable strap pin, plus a memory and I/O responder for reads.
  Assumes no wait states and that the bench feeds o_mux_in and o_bhe_pin
  back to the pin stage.
*/
`timescale 1ns/1ps
module ebh_far_side import ebh_pkg::*; #(
  parameter logic [15:0] PULLS = 16'hc3a5
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_status_n,
  input wire logic [2:0] i_status_oe,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_mux_out,
  input wire logic i_mux_oe,
  input wire logic i_den_n,
  input wire logic i_dir,
  input wire logic i_strobes_oe,
  input wire logic i_bhe_n,
  input wire logic i_bhe_oe,
  input wire logic i_bhe_strap,
  output logic [15:0] o_mux_in,
  output logic o_bhe_pin
);
  logic [19:0] addr_q;
  logic mem_q;
  logic [1:0] hold_q;
  logic read_on;

  assign read_on = i_strobes_oe && !i_den_n && !i_dir;

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      hold_q <= 2'h0;
    end else begin
      // The top status bit picks memory or I/O, so each answers differently.
      if (i_status_oe == 3'h7 && i_status_n != 3'h7) begin
        addr_q <= i_addr;
        mem_q <= i_status_n[2];
      end
      // Read data is held three cycles after the transceiver turns off.
      hold_q <= read_on ? 2'h3 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    end
  end

  // A released bus falls back to the pulls, which also set the straps.
  assign o_mux_in = i_mux_oe ? i_mux_out : (read_on || hold_q != 2'h0) ?
    (addr_q[15:0] ^ (mem_q ? 16'h5a5a : 16'ha5a5)) : PULLS;
  assign o_bhe_pin = i_bhe_oe ? i_bhe_n : i_bhe_strap;
endmodule // ebh_far_side

// ---- verif/ebh_bus_pins_tb.sv ----
/*
  Self-checking bench for the bus pin stage: bus cycles of every kind but passive, hold
  handover, scan mode and reset straps.
  Assumes the far-side model resolves the muxed bus and the strap pin.
*/
`timescale 1ns/1ps
module ebh_bus_pins_tb import ebh_pkg::*;;
  localparam logic [15:0] PULLS = 16'hc3a5;
  logic clk, rst, vld, byte_high_enable_n, jen, tdo, hreq, strap, ready, rv, tck, tms, pao, mxo, bheo;
  logic bhen, bhepin, wr_n, write_upper_byte_n, write_lower_byte_n, transceiver_enable_n, dir, soe, hack, ape, upper_memory_select_n, ocp, lower_memory_select_n;
  logic [2:0] kind, stn, stoe, stpin;
  logic [19:0] addr, pa;
  logic [15:0] wd, rd, mxout, mxin, cfg;
  logic [6:0] pcs;
  logic [3:0] mcs;
  int err_total, n_checks, cyc;
  bit ape_exp;

  ebh_bus_pins dut_u (.i_sys_clk(clk), .i_reset(rst), .i_req_valid(vld), .i_req_kind(kind),
    .i_req_addr(addr), .i_req_wdata(wd), .i_req_byte_high_enable_n(byte_high_enable_n), .o_req_ready(ready),
    .o_rdata(rd), .o_rdata_valid(rv), .i_jtag_enable(jen), .i_jtag_tdo(tdo), .o_jtag_tck(tck),
    .o_jtag_tms(tms), .o_output_clock_primary(ocp), .o_cycle_status_n(stn),
    .o_cycle_status_oe(stoe), .i_cycle_status_pin(stpin), .o_plain_address_bus(pa),
    .o_plain_address_oe(pao), .i_muxed_addr_data_bus(mxin), .o_muxed_addr_data_bus(mxout),
    .o_muxed_addr_data_oe(mxo), .i_byte_high_enable_pin(bhepin), .o_byte_high_enable_n(bhen),
    .o_byte_high_enable_oe(bheo), .o_write_strobe_n(wr_n), .o_write_upper_byte_n(write_upper_byte_n),
    .o_write_lower_byte_n(write_lower_byte_n), .o_transceiver_enable_n(transceiver_enable_n), .o_transfer_direction(dir),
    .o_strobes_oe(soe), .i_hold_request(hreq), .o_hold_acknowledge(hack),
    .o_reset_config_register(cfg), .o_address_phase_enabled(ape),
    .i_upper_memory_select_n(1'b0), .i_lower_memory_select_n(1'b0),
    .i_midrange_memory_selects_n(4'h0), .i_peripheral_selects_n(7'h00),
    .o_upper_memory_select_n(upper_memory_select_n), .o_lower_memory_select_n(lower_memory_select_n),
    .o_midrange_memory_selects_n(mcs), .o_peripheral_selects_n(pcs));

  ebh_far_side #(.PULLS(PULLS)) far_u (.i_sys_clk(clk), .i_reset(rst), .i_status_n(stn),
    .i_status_oe(stoe), .i_addr(pa), .i_mux_out(mxout), .i_mux_oe(mxo), .i_den_n(transceiver_enable_n),
    .i_dir(dir), .i_strobes_oe(soe), .i_bhe_n(bhen), .i_bhe_oe(bheo), .i_bhe_strap(strap),
    .o_mux_in(mxin), .o_bhe_pin(bhepin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_reset(input bit s);
    @(negedge clk);
    rst = 1'b1;
    strap = s;
    ape_exp = s;
    repeat (3) @(negedge clk);
    chk("status_oe", 3'h0, stoe);
    chk("addr_oe", 1'b0, pao);
    chk("muxed_oe", 1'b0, mxo);
    chk("strobes_oe", 2'h0, {soe, bheo});
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("config", PULLS, cfg);
    chk("addr_phase", s, ape);
  endtask

  task automatic t_cycle(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d,
                         input bit b, input bit mid);
    int i;
    bit w;
    bit r;
    w = (k == 3'h2 || k == 3'h6);
    r = (k == 3'h0 || k == 3'h1 || k == 3'h4 || k == 3'h5);
    vld = 1'b1;
    kind = k;
    addr = a;
    wd = d;
    byte_high_enable_n = b;
    for (i = 0; i < 30 && ready !== 1'b1; i++) @(negedge clk);
    chk("ready", 1'b1, ready);
    @(negedge clk);
    vld = 1'b0;
    chk("status", k, stn);
    chk("outclk_high", 1'b1, ocp);
    chk("selects_pass", 13'h0000, {upper_memory_select_n, lower_memory_select_n, mcs, pcs});
    chk("plain_addr", a, pa);
    chk("bhe", b, bhen);
    @(negedge clk);
    if (mid) hreq = 1'b1;
    chk("muxed_oe", ape_exp, mxo);
    if (ape_exp) chk("muxed_addr", a[15:0], mxout);
    chk("outclk_low", 1'b0, ocp);
    @(negedge clk);
    chk("wr_n", !w, wr_n);
    chk("whb", b | !w | !a[0], write_upper_byte_n);
    chk("wlb", b | !w | a[0], write_lower_byte_n);
    if (w) chk("wdata", d, mxout);
    chk("dir", w, dir);
    chk("den", k == 3'h3, transceiver_enable_n);
    for (i = 3; i <= 8; i++) begin
      @(negedge clk);
      if (mid && i < 8) chk("early_ack", 1'b0, hack);
      if (i == 4) chk("passive", 3'h7, stn);
      if (i == 5 || i == 6) chk("wr_n_late", i == 6 || !w, wr_n);
    end
    chk("rvalid", r, rv);
    if (r) chk("rdata", a[15:0] ^ (k[2] ? 16'h5a5a : 16'ha5a5), rd);
  endtask

  task automatic t_hold(input int lo, input int hi);
    int i;
    hreq = 1'b1;
    for (i = 0; i < 12 && hack !== 1'b1; i++) @(negedge clk);
    chk("ack_delay", 1'b1, i >= lo && i <= hi);
    chk("hold_oe", 9'h000, {stoe, pao, mxo, soe, bheo});
    chk("selects", 13'h1fff, {upper_memory_select_n, lower_memory_select_n, mcs, pcs});
    repeat (4) @(negedge clk);
    chk("ack_stays", 1'b1, hack);
    hreq = 1'b0;
    for (i = 0; i < 12 && hack !== 1'b0; i++) @(negedge clk);
    chk("release", 1'b1, i >= 2 && i <= 5);
  endtask

  task automatic t_jtag();
    int v;
    jen = 1'b1;
    for (v = 0; v < 2; v++) begin
      tdo = v[0];
      stpin = {1'b0, v[0], !v[0]};
      repeat (4) @(negedge clk);
      chk("scan", {v[0], 3'h4, v[0], !v[0]}, {stn[2], stoe, tck, tms});
    end
    jen = 1'b0;
    stpin = 3'h7;
  endtask

  initial begin
    int k;
    rst = 1'b1;
    vld = 1'b0;
    kind = 3'h7;
    addr = 20'h00000;
    wd = 16'h0000;
    byte_high_enable_n = 1'b0;
    jen = 1'b0;
    tdo = 1'b0;
    hreq = 1'b0;
    strap = 1'b1;
    stpin = 3'h7;
    t_reset(1'b1);
    for (k = 0; k < 7; k++) begin
      t_cycle(k[2:0], 20'h3c5a0 | 20'(k), {k[2:0], 13'h0a5c}, k[1], 1'b0);
    end
    t_cycle(EBH_CYC_IO_WR, 20'h0a5f1, 16'hbeef, 1'b0, 1'b0);
    t_cycle(EBH_CYC_MEM_WR, 20'h0a5f2, 16'h1234, 1'b0, 1'b0);
    t_hold(3, 6);
    t_cycle(EBH_CYC_MEM_WR, 20'h7fffe, 16'hffff, 1'b0, 1'b1);
    t_hold(0, 4);
    t_cycle(EBH_CYC_MEM_RD, 20'h00003, 16'h0000, 1'b0, 1'b0);
    t_jtag();
    t_reset(1'b0);
    t_cycle(EBH_CYC_MEM_RD, 20'h0f00f, 16'h0000, 1'b1, 1'b0);
    end_of_test();
  end
endmodule // ebh_bus_pins_tb
